// [src/scc_cache_end.sv]
// Behaviour
// - Miss loads block, then prefetches next block
// - Prefetch abandoned when next block present
// - Status code enables prefetch per read
// - Victim is least recently used way
// - Every write also goes to main storage
// - Single write buffer drains while CPU continues
// - Multiplexed bus, strobes, lock, wait, errors, burst
// - Busy chain orders writes between parallel caches
// - Snooped write addresses invalidate cached blocks
// - Address phase carries four qualifier bits
// - Byte lanes double as eoc, uncorrectable error, wait
// - External logic supplies snoop check address
// - 128 sets, four ways, 16-byte blocks
// - Tag compare; hit returns data, else miss
// - Missed word forwarded before block stored
`timescale 1ns/100ps
`default_nettype none
`include "scc_defines.svh"
module scc_cache_end
    import scc_pkg::*;
#(
    parameter int ADDR_W = `SCC_ADDR_W,
    parameter int SETS = `SCC_SETS
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    scc_cpu_if.cache cpu,
    input wire logic [31:0] ad_in,
    output logic [31:0] ad_out,
    output logic ad_oe,
    output logic addr_strobe_out,
    output logic data_strobe_out,
    input wire logic [3:0] lane_in,
    output logic [3:0] lane_out,
    output logic [3:0] lane_oe,
    input wire logic burst_mode_in,
    input wire logic write_buffer_busy_chain_in,
    output logic write_buffer_busy_chain_out,
    output logic write_buffer_busy_chain_oe,
    input wire logic snoop_valid_in,
    input wire logic [ADDR_W-1:0] snoop_check_address_in
);
    localparam int IDX_W = $clog2(SETS);
    localparam int SLOT_W = IDX_W + 2;
    localparam int TAG_W = ADDR_W - IDX_W - 4;
    localparam int NSLOT = SETS * `SCC_WAYS;

    // ************
    // Storage
    // ************
    scc_word_type data_ff [NSLOT][`SCC_BLK_WORDS];
    logic [TAG_W-1:0] tag_ff [NSLOT];
    logic [NSLOT-1:0] valid_ff;
    logic [1:0] age_ff [NSLOT];
    scc_word_type blk_ff [`SCC_BLK_WORDS];

    scc_main_type main_ff;
    scc_bus_type bus_ff;
    logic fill_req_ff, fill_pf_ff, fill_lock_ff, pf_en_ff, kill_ff;
    logic [ADDR_W-1:0] fill_addr_ff;
    logic wb_valid_ff, wb_lock_ff;
    logic [ADDR_W-1:0] wb_addr_ff;
    scc_word_type wb_data_ff;
    logic [3:0] wb_be_ff;
    logic is_rd_ff, burst_ff, uncorrectable_error_in_ff, byp_rdy_ff, byp_err_ff;
    logic [1:0] beat_ff, word_ff;
    scc_word_type bypass_ff;

    function automatic logic [2:0] look(input logic [ADDR_W-1:0] a);
        logic [2:0] r;
        logic [SLOT_W-1:0] s;
        r = 3'h0;
        for (int w = 0; w < `SCC_WAYS; w++) begin
            s = {a[IDX_W+3:4], 2'(w)};
            if (valid_ff[s] && tag_ff[s] == a[ADDR_W-1:IDX_W+4]) begin
                r = {1'b1, 2'(w)};
            end
        end
        return r;
    endfunction

    // ************
    // Lookup and CPU answer
    // ************
    logic [2:0] cpu_look, pf_look, snp_look;
    logic [SLOT_W-1:0] cpu_slot, vslot, touch_slot;
    logic [IDX_W-1:0] fset;
    logic [ADDR_W-1:0] pf_addr;
    logic [1:0] vway;
    logic idle, rd_hit, rd_miss_go, wr_go, take, last, snp_match;
    logic commit_ok, touch_en, bus_done;

    assign idle = (main_ff == M_IDLE) && cpu.req;
    assign cpu_look = look(cpu.addr);
    assign cpu_slot = {cpu.addr[IDX_W+3:4], cpu_look[1:0]};
    assign rd_hit = idle && !cpu.we && cpu_look[2];
    assign rd_miss_go = idle && !cpu.we && !cpu_look[2] && !wb_valid_ff
        && (bus_ff == B_IDLE);
    assign wr_go = idle && cpu.we && !wb_valid_ff;
    assign cpu.cpu_ready_out = rd_hit || wr_go || byp_rdy_ff;
    assign cpu.rdata = byp_rdy_ff ? bypass_ff
        : data_ff[cpu_slot][cpu.addr[3:2]];
    assign cpu.err = byp_rdy_ff && byp_err_ff;

    assign fset = fill_addr_ff[IDX_W+3:4];
    assign pf_addr = {fill_addr_ff[ADDR_W-1:4] + 1'b1, 4'h0};
    assign pf_look = look(pf_addr);
    assign snp_look = look(snoop_check_address_in);
    assign snp_match = snoop_valid_in && (main_ff != M_IDLE)
        && snoop_check_address_in[ADDR_W-1:4] == fill_addr_ff[ADDR_W-1:4];
    assign commit_ok = (main_ff == M_COMMIT) && !uncorrectable_error_in_ff && !kill_ff
        && !snp_match;

    // Lowest invalid way first, otherwise the oldest one
    always_comb begin
        vway = 2'h0;
        for (int w = 0; w < `SCC_WAYS; w++) begin
            if (age_ff[{fset, 2'(w)}] == 2'h3) begin
                vway = 2'(w);
            end
        end
        for (int w = `SCC_WAYS - 1; w >= 0; w--) begin
            if (!valid_ff[{fset, 2'(w)}]) begin
                vway = 2'(w);
            end
        end
    end
    assign vslot = {fset, vway};
    assign touch_en = rd_hit || (wr_go && cpu_look[2]) || commit_ok;
    assign touch_slot = commit_ok ? vslot : cpu_slot;

    // ************
    // Miss sequencing
    // ************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            main_ff <= M_IDLE;
            fill_req_ff <= 1'b0;
            fill_pf_ff <= 1'b0;
            fill_lock_ff <= 1'b0;
            fill_addr_ff <= '0;
            pf_en_ff <= 1'b0;
            kill_ff <= 1'b0;
        end else begin
            if (bus_ff == B_IDLE && fill_req_ff) begin
                fill_req_ff <= 1'b0;
            end
            if (snp_match) begin
                kill_ff <= 1'b1;
            end
            case (main_ff)
                M_IDLE: begin
                    if (rd_miss_go) begin
                        fill_req_ff <= 1'b1;
                        fill_addr_ff <= cpu.addr;
                        fill_pf_ff <= 1'b0;
                        fill_lock_ff <= cpu.cycle_status_code[`SCC_STS_LOCK];
                        pf_en_ff <= cpu.cycle_status_code[`SCC_STS_PF];
                        kill_ff <= 1'b0;
                        main_ff <= M_MISS;
                    end
                end
                M_MISS: begin
                    if (bus_done) begin
                        main_ff <= M_COMMIT;
                    end
                end
                M_COMMIT: begin
                    if (pf_en_ff && !fill_pf_ff && !uncorrectable_error_in_ff) begin
                        main_ff <= M_PFCHK;
                    end else begin
                        main_ff <= M_IDLE;
                    end
                end
                M_PFCHK: begin
                    if (pf_look[2]) begin
                        main_ff <= M_IDLE;
                    end else begin
                        fill_req_ff <= 1'b1;
                        fill_addr_ff <= pf_addr;
                        fill_pf_ff <= 1'b1;
                        kill_ff <= 1'b0;
                        main_ff <= M_MISS;
                    end
                end
                default: main_ff <= M_IDLE;
            endcase
        end
    end

    // ************
    // Directory, data store and age update
    // ************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            valid_ff <= '0;
        end else begin
            if (commit_ok) begin
                valid_ff[vslot] <= 1'b1;
            end
            if (snoop_valid_in && snp_look[2]) begin
                valid_ff[{snoop_check_address_in[IDX_W+3:4],
                    snp_look[1:0]}] <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (commit_ok) begin
            tag_ff[vslot] <= fill_addr_ff[ADDR_W-1:IDX_W+4];
        end
    end

    // Whole block stored at once once the load buffer is complete
    always_ff @(posedge sys_clk) begin
        if (commit_ok) begin
            for (int k = 0; k < `SCC_BLK_WORDS; k++) begin
                data_ff[vslot][k] <= blk_ff[k];
            end
        end else if (wr_go && cpu_look[2]) begin
            for (int b = 0; b < 4; b++) begin
                if (cpu.be[b]) begin
                    data_ff[cpu_slot][cpu.addr[3:2]][8*b +: 8] <=
                        cpu.wdata[8*b +: 8];
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < NSLOT; i++) begin
                age_ff[i] <= 2'(i);
            end
        end else if (touch_en) begin
            for (int w = 0; w < `SCC_WAYS; w++) begin
                if (2'(w) == touch_slot[1:0]) begin
                    age_ff[{touch_slot[SLOT_W-1:2], 2'(w)}] <= 2'h0;
                end else if (age_ff[{touch_slot[SLOT_W-1:2], 2'(w)}]
                    < age_ff[touch_slot]) begin
                    age_ff[{touch_slot[SLOT_W-1:2], 2'(w)}] <=
                        age_ff[{touch_slot[SLOT_W-1:2], 2'(w)}] + 2'h1;
                end
            end
        end
    end

    // ************
    // Write buffer
    // ************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wb_valid_ff <= 1'b0;
            wb_lock_ff <= 1'b0;
            wb_addr_ff <= '0;
            wb_data_ff <= 32'h0;
            wb_be_ff <= 4'h0;
        end else if (wr_go) begin
            wb_valid_ff <= 1'b1;
            wb_lock_ff <= cpu.cycle_status_code[`SCC_STS_LOCK];
            wb_addr_ff <= cpu.addr;
            wb_data_ff <= cpu.wdata;
            wb_be_ff <= cpu.be;
        end else if (bus_done && !is_rd_ff) begin
            wb_valid_ff <= 1'b0;
        end
    end

    // ************
    // System bus sequencer
    // ************
    assign take = (bus_ff == B_DATA) && !lane_in[`SCC_LANE_WAIT];
    assign last = !is_rd_ff || beat_ff == 2'h3;
    assign bus_done = bus_ff == B_EOC;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            bus_ff <= B_IDLE;
            is_rd_ff <= 1'b0;
            burst_ff <= 1'b0;
            beat_ff <= 2'h0;
            word_ff <= 2'h0;
        end else begin
            case (bus_ff)
                B_IDLE: begin
                    beat_ff <= 2'h0;
                    if (fill_req_ff) begin
                        bus_ff <= B_ADDR;
                        is_rd_ff <= 1'b1;
                        burst_ff <= burst_mode_in;
                        word_ff <= fill_addr_ff[3:2];
                    end else if (wb_valid_ff
                        && !write_buffer_busy_chain_in) begin
                        bus_ff <= B_ADDR;
                        is_rd_ff <= 1'b0;
                        burst_ff <= 1'b0;
                        word_ff <= wb_addr_ff[3:2];
                    end
                end
                B_ADDR: bus_ff <= B_DATA;
                B_DATA: begin
                    if (take) begin
                        beat_ff <= beat_ff + 2'h1;
                        word_ff <= word_ff + 2'h1;
                        if (last) begin
                            bus_ff <= B_EOC;
                        end else if (!burst_ff) begin
                            bus_ff <= B_ADDR;
                        end
                    end
                end
                B_EOC: bus_ff <= B_IDLE;
                default: bus_ff <= B_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (take && is_rd_ff) begin
            blk_ff[word_ff] <= ad_in;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            uncorrectable_error_in_ff <= 1'b0;
            byp_rdy_ff <= 1'b0;
            byp_err_ff <= 1'b0;
            bypass_ff <= 32'h0;
        end else begin
            byp_rdy_ff <= take && is_rd_ff && !fill_pf_ff
                && word_ff == fill_addr_ff[3:2];
            if (take && is_rd_ff && word_ff == fill_addr_ff[3:2]) begin
                bypass_ff <= ad_in;
                byp_err_ff <= uncorrectable_error_in_ff || lane_in[`SCC_LANE_UNCORRECTABLE_ERROR_IN];
            end
            if (bus_ff == B_IDLE && fill_req_ff) begin
                uncorrectable_error_in_ff <= 1'b0;
            end else if (take && is_rd_ff && lane_in[`SCC_LANE_UNCORRECTABLE_ERROR_IN]) begin
                uncorrectable_error_in_ff <= 1'b1;
            end
        end
    end

    // Address phase: qualifiers in the top nibble
    logic [ADDR_W-1:0] op_addr;
    assign op_addr = is_rd_ff ? {fill_addr_ff[ADDR_W-1:4], word_ff, 2'h0}
        : wb_addr_ff;
    always_comb begin
        ad_out = 32'h0;
        lane_out = 4'h0;
        if (bus_ff == B_ADDR) begin
            ad_out[27:0] = 28'(op_addr);
            ad_out[`SCC_QUAL_MEM] = 1'b1;
            ad_out[`SCC_QUAL_RD] = is_rd_ff;
            ad_out[`SCC_QUAL_LOCK] = is_rd_ff ? fill_lock_ff : wb_lock_ff;
            ad_out[`SCC_QUAL_PF] = is_rd_ff && fill_pf_ff;
            lane_out = is_rd_ff ? 4'hf : wb_be_ff;
        end else if (bus_ff == B_DATA && !is_rd_ff) begin
            ad_out = wb_data_ff;
        end else if (bus_ff == B_EOC) begin
            lane_out[`SCC_LANE_EOC] = 1'b1;
        end
    end
    assign ad_oe = (bus_ff == B_ADDR) || (bus_ff == B_DATA && !is_rd_ff);
    assign addr_strobe_out = bus_ff == B_ADDR;
    assign data_strobe_out = bus_ff == B_DATA;
    assign lane_oe = (bus_ff == B_ADDR) ? 4'hf
        : (bus_ff == B_IDLE) ? 4'h0 : 4'h1;
    assign write_buffer_busy_chain_out = 1'b1;
    assign write_buffer_busy_chain_oe = !is_rd_ff && (bus_ff != B_IDLE);
endmodule
`default_nettype wire

// [include/scc_defines.svh]
`ifndef SCC_DEFINES_SVH
`define SCC_DEFINES_SVH
// ************
// Geometry
// ************
`define SCC_ADDR_W 28
`define SCC_SETS 128
`define SCC_WAYS 4
`define SCC_BLK_WORDS 4
// ************
// Address phase qualifiers on the multiplexed bus
// ************
`define SCC_QUAL_MEM 31
`define SCC_QUAL_RD 30
`define SCC_QUAL_LOCK 29
`define SCC_QUAL_PF 28
// ************
// Byte enable lanes used as control
// ************
`define SCC_LANE_EOC 0
`define SCC_LANE_UNCORRECTABLE_ERROR_IN 1
`define SCC_LANE_WAIT 2
`define SCC_LANE_CORRECTABLE_ERROR_IN 3
// ************
// Cycle status code bits
// ************
`define SCC_STS_PF 0
`define SCC_STS_LOCK 1
`define SCC_STS_W 3
`endif

// [include/scc_pkg.sv]
package scc_pkg;
    typedef logic [31:0] scc_word_type;
    typedef enum logic [3:0] {
        M_IDLE = 4'h1,
        M_MISS = 4'h2,
        M_COMMIT = 4'h4,
        M_PFCHK = 4'h8
    } scc_main_type;
    typedef enum logic [3:0] {
        B_IDLE = 4'h1,
        B_ADDR = 4'h2,
        B_DATA = 4'h4,
        B_EOC = 4'h8
    } scc_bus_type;
endpackage

// [include/scc_cpu_if.sv]
`timescale 1ns/100ps
`default_nettype none
`include "scc_defines.svh"
interface scc_cpu_if #(
    parameter int ADDR_W = `SCC_ADDR_W
);
    logic req;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic [`SCC_STS_W-1:0] cycle_status_code;
    logic cpu_ready_out;
    logic [31:0] rdata;
    logic err;
    modport cpu (
        output req, we, addr, wdata, be, cycle_status_code,
        input cpu_ready_out, rdata, err
    );
    modport cache (
        input req, we, addr, wdata, be, cycle_status_code,
        output cpu_ready_out, rdata, err
    );
endinterface
`default_nettype wire

// [src/scc_cpu_end.sv]
`timescale 1ns/100ps
`default_nettype none
`include "scc_defines.svh"
module scc_cpu_end
    import scc_pkg::*;
#(
    parameter int ADDR_W = `SCC_ADDR_W
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    scc_cpu_if.cpu cpu,
    input wire logic usr_req,
    input wire logic usr_we,
    input wire logic [ADDR_W-1:0] usr_addr,
    input wire logic [31:0] usr_wdata,
    input wire logic [3:0] usr_be,
    input wire logic usr_prefetch,
    input wire logic usr_lock,
    output logic usr_busy,
    output logic usr_done,
    output scc_word_type usr_rdata,
    output logic usr_err
);
    // ************
    // Request holding
    // ************
    logic pend_ff, we_ff;
    logic [ADDR_W-1:0] addr_ff;
    scc_word_type wdata_ff;
    logic [3:0] be_ff;
    logic [`SCC_STS_W-1:0] sts_ff, nxt_sts;

    always_comb begin
        nxt_sts = '0;
        nxt_sts[`SCC_STS_PF] = usr_prefetch && !usr_we;
        nxt_sts[`SCC_STS_LOCK] = usr_lock;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pend_ff <= 1'b0;
            we_ff <= 1'b0;
            addr_ff <= '0;
            wdata_ff <= 32'h0;
            be_ff <= 4'h0;
            sts_ff <= '0;
        end else if (pend_ff && cpu.cpu_ready_out) begin
            pend_ff <= 1'b0;
        end else if (!pend_ff && usr_req) begin
            pend_ff <= 1'b1;
            we_ff <= usr_we;
            addr_ff <= usr_addr;
            wdata_ff <= usr_wdata;
            be_ff <= usr_be;
            sts_ff <= nxt_sts;
        end
    end

    // ************
    // Answer capture
    // ************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            usr_done <= 1'b0;
            usr_rdata <= 32'h0;
            usr_err <= 1'b0;
        end else begin
            usr_done <= pend_ff && cpu.cpu_ready_out;
            if (pend_ff && cpu.cpu_ready_out) begin
                usr_err <= cpu.err;
                if (!we_ff) begin
                    usr_rdata <= cpu.rdata;
                end
            end
        end
    end

    assign cpu.req = pend_ff;
    assign cpu.we = we_ff;
    assign cpu.addr = addr_ff;
    assign cpu.wdata = wdata_ff;
    assign cpu.be = be_ff;
    assign cpu.cycle_status_code = sts_ff;
    assign usr_busy = pend_ff;
endmodule
`default_nettype wire

// [test/scc_bus_chk.sv]
`timescale 1ns/100ps
`default_nettype none
`include "scc_defines.svh"
module scc_bus_chk #(
    parameter int ADDR_W = `SCC_ADDR_W
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic req,
    input wire logic we,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic cpu_ready_out,
    input wire logic err,
    input wire logic [31:0] ad_out,
    input wire logic ad_oe,
    input wire logic addr_strobe_out,
    input wire logic data_strobe_out,
    input wire logic [3:0] lane_in,
    input wire logic [3:0] lane_out,
    input wire logic [3:0] lane_oe,
    input wire logic write_buffer_busy_chain_oe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // ************
    // CPU link
    // ************
    a_ready_needs_req: assert property (cpu_ready_out |-> req)
        else $error("ready no req");
    a_ready_one_cycle: assert property (cpu_ready_out |=> !cpu_ready_out)
        else $error("ready too long");
    a_req_held_until: assert property (req && !cpu_ready_out |=>
        req && $stable(addr) && $stable(we))
        else $error("req dropped");
    a_err_with_ready: assert property (err |-> cpu_ready_out)
        else $error("stray err");
    a_write_goes_through: assert property (req && we && cpu_ready_out
        |-> ##[1:40] (addr_strobe_out && !ad_out[`SCC_QUAL_RD]))
        else $error("write not sent");
    // ************
    // System bus
    // ************
    a_addr_one_cycle: assert property (addr_strobe_out |=> !addr_strobe_out)
        else $error("addr too long");
    a_addr_qualifiers: assert property (addr_strobe_out |-> ad_oe
        && ad_out[`SCC_QUAL_MEM] && lane_oe == 4'hf)
        else $error("addr drive");
    a_eoc_after_data: assert property ($fell(data_strobe_out) |->
        (lane_out[`SCC_LANE_EOC] && lane_oe[`SCC_LANE_EOC]) || addr_strobe_out)
        else $error("no eoc");
    a_wait_holds_data: assert property (data_strobe_out && lane_in[`SCC_LANE_WAIT]
        |=> data_strobe_out && !addr_strobe_out)
        else $error("wait ignored");
    a_write_owns_chain: assert property (addr_strobe_out
        && !ad_out[`SCC_QUAL_RD] |-> write_buffer_busy_chain_oe)
        else $error("no busy chain");
    c_read_fill: cover property (addr_strobe_out && ad_out[`SCC_QUAL_RD]);
    c_prefetch: cover property (addr_strobe_out && ad_out[`SCC_QUAL_PF]);
    c_write: cover property (addr_strobe_out && !ad_out[`SCC_QUAL_RD]);
    c_wait: cover property (data_strobe_out && lane_in[`SCC_LANE_WAIT]);
endmodule
`default_nettype wire

// [test/single_chip_cache_subsystem_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module single_chip_cache_subsystem_tb
    import scc_pkg::*;
;
    typedef struct packed {
        logic we;
        logic [27:0] addr;
        logic [31:0] data;
        logic pf;
        logic [3:0] nas;
        logic [3:0] npf;
    } scc_row_type;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic usr_req = 1'b0, usr_we = 1'b0, usr_prefetch = 1'b0, usr_lock = 1'b0;
    logic [3:0] usr_be = 4'hf;
    logic [27:0] usr_addr = 28'h0;
    logic [31:0] usr_wdata = 32'h0;
    logic usr_busy, usr_done, usr_err;
    scc_word_type usr_rdata;
    logic [31:0] ad_in = 32'h0;
    logic [31:0] ad_out;
    logic ad_oe, addr_strobe_out, data_strobe_out;
    logic [3:0] lane_in, lane_out, lane_oe;
    logic burst_mode_in = 1'b1, chain_out, chain_oe;
    logic snoop_valid_in = 1'b0;
    logic [27:0] snoop_addr = 28'h0;
    logic wait_b = 1'b0, stall_en = 1'b0, uncorrectable_error_in_inj = 1'b0, rd = 1'b0;
    logic [27:0] cur = 28'h0, wr_addr = 28'h0;
    logic [31:0] wr_data = 32'h0, n_as = 32'h0, n_pf = 32'h0;
    logic [31:0] cyc = 32'h0, as_cyc = 32'h0, rdy_cyc = 32'h0;
    logic [31:0] b_as, b_pf;
    int n_fail = 0;
    int cmp_count = 0;
    scc_row_type rows [17] = '{
        '{1'h0, 28'h100, 32'h0, 1'h0, 4'h1, 4'h0},
        '{1'h0, 28'h104, 32'h0, 1'h0, 4'h0, 4'h0},
        '{1'h1, 28'h108, 32'h11223344, 1'h0, 4'h1, 4'h0},
        '{1'h0, 28'h108, 32'h11223344, 1'h0, 4'h0, 4'h0},
        '{1'h0, 28'h200, 32'h0, 1'h1, 4'h2, 4'h1},
        '{1'h0, 28'h214, 32'h0, 1'h0, 4'h0, 4'h0},
        '{1'h0, 28'h1f0, 32'h0, 1'h1, 4'h1, 4'h0},
        '{1'h0, 28'h300, 32'h0, 1'h0, 4'h1, 4'h0},
        '{1'h0, 28'h310, 32'h0, 1'h0, 4'h1, 4'h0},
        '{1'h0, 28'h050, 32'h0, 1'h0, 4'h1, 4'h0},
        '{1'h0, 28'h850, 32'h0, 1'h0, 4'h1, 4'h0},
        '{1'h0, 28'h1050, 32'h0, 1'h0, 4'h1, 4'h0},
        '{1'h0, 28'h1850, 32'h0, 1'h0, 4'h1, 4'h0},
        '{1'h0, 28'h054, 32'h0, 1'h0, 4'h0, 4'h0},
        '{1'h0, 28'h2050, 32'h0, 1'h0, 4'h1, 4'h0},
        '{1'h0, 28'h058, 32'h0, 1'h0, 4'h0, 4'h0},
        '{1'h0, 28'h854, 32'h0, 1'h0, 4'h1, 4'h0}
    };
    scc_cpu_if i_scc_cpu_if ();
    scc_cpu_end i_scc_cpu_end (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .cpu(i_scc_cpu_if),
        .usr_req(usr_req), .usr_we(usr_we), .usr_addr(usr_addr),
        .usr_wdata(usr_wdata), .usr_be(usr_be), .usr_prefetch(usr_prefetch),
        .usr_lock(usr_lock), .usr_busy(usr_busy), .usr_done(usr_done),
        .usr_rdata(usr_rdata), .usr_err(usr_err)
    );
    scc_cache_end i_scc_cache_end (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .cpu(i_scc_cpu_if),
        .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe),
        .addr_strobe_out(addr_strobe_out), .data_strobe_out(data_strobe_out),
        .lane_in(lane_in), .lane_out(lane_out), .lane_oe(lane_oe),
        .burst_mode_in(burst_mode_in),
        .write_buffer_busy_chain_in(chain_out & chain_oe),
        .write_buffer_busy_chain_out(chain_out),
        .write_buffer_busy_chain_oe(chain_oe),
        .snoop_valid_in(snoop_valid_in), .snoop_check_address_in(snoop_addr)
    );
    scc_bus_chk i_scc_bus_chk (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .req(i_scc_cpu_if.req),
        .we(i_scc_cpu_if.we), .addr(i_scc_cpu_if.addr),
        .cpu_ready_out(i_scc_cpu_if.cpu_ready_out), .err(i_scc_cpu_if.err),
        .ad_out(ad_out), .ad_oe(ad_oe), .addr_strobe_out(addr_strobe_out),
        .data_strobe_out(data_strobe_out), .lane_in(lane_in),
        .lane_out(lane_out), .lane_oe(lane_oe),
        .write_buffer_busy_chain_oe(chain_oe)
    );
    // ************
    // Main storage on the far side of the bus
    // ************
    assign lane_in = {1'b0, wait_b, uncorrectable_error_in_inj & data_strobe_out, 1'b0};
    function automatic logic [31:0] mem_val(input logic [27:0] a);
        return {4'hc, a[27:2], 2'h1};
    endfunction
    always #2.5 sys_clk = ~sys_clk;
    always @(negedge sys_clk) begin
        ad_in <= (data_strobe_out && rd) ? mem_val(cur) : ~ad_in;
        wait_b <= stall_en && data_strobe_out && !wait_b;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 32'h1;
        if (cyc == 32'd20000) begin
            n_fail++;
            conclude();
        end
        if (i_scc_cpu_if.cpu_ready_out === 1'b1) rdy_cyc <= cyc;
        if (addr_strobe_out === 1'b1) begin
            n_as <= n_as + 32'h1;
            n_pf <= n_pf + {31'h0, ad_out[28]};
            cur <= ad_out[27:0];
            rd <= ad_out[30];
            as_cyc <= cyc;
        end else if (data_strobe_out === 1'b1 && !wait_b) begin
            if (!rd) begin
                wr_addr <= cur;
                wr_data <= ad_out;
            end else cur[3:2] <= cur[3:2] + 2'h1;
        end
    end
    // ************
    // Tasks
    // ************
    task automatic check(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic op(input logic w, input logic [27:0] a,
            input logic [31:0] d, input logic p, input int idle);
        int k;
        @(negedge sys_clk);
        usr_we = w;
        usr_addr = a;
        usr_wdata = d;
        usr_prefetch = p;
        usr_req = 1'b1;
        @(negedge sys_clk);
        usr_req = 1'b0;
        k = 0;
        while (usr_done !== 1'b1 && k < 200) begin
            @(negedge sys_clk);
            k++;
        end
        check("done", {31'h0, usr_done}, 32'h1);
        repeat (idle) @(negedge sys_clk);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // ************
    // Sequence
    // ************
    initial begin
        repeat (10) @(negedge sys_clk);
        check("reset_oe", {31'h0, ad_oe}, 32'h0);
        check("reset_busy", {31'h0, usr_busy}, 32'h0);
        repeat (10) @(negedge sys_clk);
        sys_rst = 1'b0;
        foreach (rows[i]) begin
            b_as = n_as;
            b_pf = n_pf;
            op(rows[i].we, rows[i].addr, rows[i].data, rows[i].pf, 30);
            check("bus_cycles", n_as - b_as, {28'h0, rows[i].nas});
            check("pf_cycles", n_pf - b_pf, {28'h0, rows[i].npf});
            if (rows[i].we) check("wr_data", wr_data, rows[i].data);
            else check("rdata", usr_rdata, rows[i].data != 0 ?
                rows[i].data : mem_val(rows[i].addr));
        end
        snoop_addr = 28'h100;
        snoop_valid_in = 1'b1;
        @(negedge sys_clk);
        snoop_valid_in = 1'b0;
        b_as = n_as;
        op(1'b0, 28'h100, 32'h0, 1'b0, 30);
        check("snoop_miss", n_as - b_as, 32'h1);
        uncorrectable_error_in_inj = 1'b1;
        op(1'b0, 28'h400, 32'h0, 1'b1, 30);
        check("uncorrectable_error_in", {31'h0, usr_err}, 32'h1);
        uncorrectable_error_in_inj = 1'b0;
        b_as = n_as;
        op(1'b0, 28'h400, 32'h0, 1'b0, 30);
        check("uncorrectable_error_in_not_kept", n_as - b_as, 32'h1);
        burst_mode_in = 1'b0;
        b_as = n_as;
        op(1'b0, 28'h500, 32'h0, 1'b0, 30);
        check("single_addr", n_as - b_as, 32'h4);
        check("single_data", usr_rdata, mem_val(28'h500));
        burst_mode_in = 1'b1;
        stall_en = 1'b1;
        op(1'b0, 28'h608, 32'h0, 1'b0, 30);
        check("wait_data", usr_rdata, mem_val(28'h608));
        stall_en = 1'b0;
        op(1'b0, 28'h700, 32'h0, 1'b0, 30);
        check("bypass_lat", rdy_cyc - as_cyc, 32'h2);
        b_as = n_as;
        op(1'b1, 28'h800, 32'ha1b2c3d4, 1'b0, 0);
        op(1'b1, 28'h804, 32'h55667788, 1'b0, 30);
        check("wr_count", n_as - b_as, 32'h2);
        check("wr_addr", {4'h0, wr_addr}, 32'h804);
        check("wr_last", wr_data, 32'h55667788);
        conclude();
    end
endmodule
`default_nettype wire
